/* File: verilog/scpm_regs.sv */
// Purpose: APB register bank for 32 shared station-address entries and their port maps.
// Assumes: One clock; APB master keeps the request stable until pready.
// Notes: Every transfer has one wait state; pready rises in the second access cycle.
//
// Overview of operation
// - One 48-bit entry takes six byte accesses.
// - Bytes move least significant byte first.
// - Data and masks decode on pages 9H-FH.
// - One two-byte port mask per entry, 32 total.
// - Entries and ports map many to many.
// - Low mask bits select ports 1 to 8.
// - High mask bits D0-D4 select ports 9-13.
// - High mask D5-D7 read byte pointer only.
// - Compare only entries valid when security starts.
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/10ps
`include "scpm_consts.svh"

module scpm_regs
  import scpm_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire scpm_apb_req_t apb_req_in,
  output scpm_apb_rsp_t apb_rsp_out,
  output logic [`SCPM_ENTRIES*`SCPM_PORTS-1:0] entry_port_map_out,
  output logic [`SCPM_ENTRIES-1:0] entry_compare_en_out,
  output logic security_run_out
);

  // Maps an aligned byte offset to the register it names.
  function automatic scpm_reg_t decode_reg(input logic [7:0] addr);
    scpm_reg_t r;
    r = SCPM_REG_NONE;
    case (addr)
      `SCPM_OFF_PAGE: begin
        r = SCPM_REG_PAGE;
      end
      `SCPM_OFF_ENTRY_SEL: begin
        r = SCPM_REG_ENTRY_SEL;
      end
      `SCPM_OFF_SHARED_ENTRY_DATA: begin
        r = SCPM_REG_DATA;
      end
      `SCPM_OFF_MASK_LOW: begin
        r = SCPM_REG_MASK_LOW;
      end
      `SCPM_OFF_MASK_HIGH: begin
        r = SCPM_REG_MASK_HIGH;
      end
      `SCPM_OFF_VALID: begin
        r = SCPM_REG_VALID;
      end
      `SCPM_OFF_SECURITY: begin
        r = SCPM_REG_SECURITY;
      end
      default: begin
        r = SCPM_REG_NONE;
      end
    endcase
    return r;
  endfunction

  // Entry registers exist only on the shared-entry pages.
  function automatic logic is_paged(input scpm_reg_t r);
    return (r == SCPM_REG_DATA) || (r == SCPM_REG_MASK_LOW) || (r == SCPM_REG_MASK_HIGH);
  endfunction

  // Byte address inside the entry store.
  function automatic logic [`SCPM_STORE_AW-1:0] store_index(input logic [`SCPM_ENTRY_W-1:0] entry,
                                                            input logic [2:0] ptr);
    logic [`SCPM_STORE_AW-1:0] e;
    e = {3'h0, entry};
    return (e << 2) + (e << 1) + {5'h00, ptr};
  endfunction

  // Next byte pointer after a data access: six steps, then back to the low byte.
  function automatic logic [2:0] next_ptr(input logic [2:0] ptr);
    logic [2:0] n;
    n = ptr + 3'h1;
    if (ptr == `SCPM_PTR_LAST) begin
      n = `SCPM_RST_PTR;
    end
    return n;
  endfunction

  // Read view of the mask high byte: pointer in the top three bits, ports 9 to 13 below.
  function automatic logic [7:0] mask_high_view(input logic [`SCPM_PORTS-1:0] mask, input logic [2:0] ptr);
    return {ptr, mask[`SCPM_PORTS-1:8]};
  endfunction

  logic [3:0] page_q;
  logic [`SCPM_ENTRY_W-1:0] entry_q;
  logic [2:0] ptr_q;
  logic [2:0] ptr_d;
  logic [`SCPM_PORTS-1:0] mask_q [`SCPM_ENTRIES];
  logic [`SCPM_ENTRIES-1:0] valid_q;
  logic [`SCPM_ENTRIES-1:0] armed_q;
  logic run_q;
  logic wait_q;
  logic [31:0] prdata_q;
  logic slverr_q;
  logic [7:0] store_rdata;

  scpm_reg_t sel_reg;
  logic on_page;
  logic bad_access;
  logic access_first;
  logic done;
  logic wr_done;
  logic rd_issue;
  logic [31:0] rd_value;
  logic wr_page;
  logic wr_entry_sel;
  logic wr_data;
  logic wr_mask_low;
  logic wr_mask_high;
  logic wr_valid;
  logic wr_security;
  logic data_step;
  logic security_start;
  logic store_rd;
  logic [`SCPM_STORE_AW-1:0] store_addr;

  assign sel_reg = decode_reg(apb_req_in.paddr);
  assign on_page = (page_q >= `SCPM_PAGE_FIRST) && (page_q <= `SCPM_PAGE_LAST);
  assign bad_access = (sel_reg == SCPM_REG_NONE) || (is_paged(sel_reg) && !on_page);
  assign access_first = apb_req_in.psel && apb_req_in.penable && !wait_q;
  assign done = apb_req_in.psel && apb_req_in.penable && wait_q;
  assign wr_done = done && apb_req_in.pwrite && !bad_access;
  assign rd_issue = apb_req_in.psel && !apb_req_in.penable && !apb_req_in.pwrite;

  // One strobe per register, raised only at the edge where an accepted write lands.
  assign wr_page = wr_done && (sel_reg == SCPM_REG_PAGE);
  assign wr_entry_sel = wr_done && (sel_reg == SCPM_REG_ENTRY_SEL);
  assign wr_data = wr_done && (sel_reg == SCPM_REG_DATA);
  assign wr_mask_low = wr_done && (sel_reg == SCPM_REG_MASK_LOW);
  assign wr_mask_high = wr_done && (sel_reg == SCPM_REG_MASK_HIGH);
  assign wr_valid = wr_done && (sel_reg == SCPM_REG_VALID);
  assign wr_security = wr_done && (sel_reg == SCPM_REG_SECURITY);
  // A refused data access leaves the pointer where it was.
  assign data_step = done && !bad_access && (sel_reg == SCPM_REG_DATA);
  assign security_start = wr_security && !run_q && apb_req_in.pwdata[`SCPM_SEC_RUN_BIT];
  assign store_rd = rd_issue && (sel_reg == SCPM_REG_DATA);
  assign store_addr = store_index(entry_q, ptr_q);

  // The store is read during the setup cycle so that its registered byte is ready in the access phase.
  scpm_entry_store u_store (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .wr_en_in(wr_data),
    .rd_en_in(store_rd),
    .addr_in(store_addr),
    .wdata_in(apb_req_in.pwdata[7:0]),
    .rdata_out(store_rdata)
  );

  // One wait state for every transfer.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= access_first;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      page_q <= `SCPM_RST_PAGE;
    end else if (wr_page) begin
      page_q <= apb_req_in.pwdata[3:0];
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      entry_q <= `SCPM_RST_ENTRY;
    end else if (wr_entry_sel) begin
      entry_q <= apb_req_in.pwdata[`SCPM_ENTRY_W-1:0];
    end
  end

  // Byte pointer steps through the six address bytes and then starts again at the low byte.
  always_comb begin
    ptr_d = ptr_q;
    if (wr_entry_sel) begin
      ptr_d = `SCPM_RST_PTR;
    end else if (data_step) begin
      ptr_d = next_ptr(ptr_q);
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ptr_q <= `SCPM_RST_PTR;
    end else begin
      ptr_q <= ptr_d;
    end
  end

  // Each entry owns its own mask; any number of bits may be set.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < `SCPM_ENTRIES; i++) begin
        mask_q[i] <= `SCPM_RST_MASK;
      end
    end else if (wr_mask_low) begin
      mask_q[entry_q][7:0] <= apb_req_in.pwdata[7:0];
    end else if (wr_mask_high) begin
      // The pointer bits above the port field are not written.
      mask_q[entry_q][`SCPM_PORTS-1:8] <= apb_req_in.pwdata[`SCPM_MHI_PORT_W-1:0];
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      valid_q <= `SCPM_RST_VALID;
    end else if (wr_valid) begin
      valid_q <= apb_req_in.pwdata;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      run_q <= 1'b0;
    end else if (wr_security) begin
      run_q <= apb_req_in.pwdata[`SCPM_SEC_RUN_BIT];
    end
  end

  // Validity is sampled only when security starts; later flag writes wait for the next start.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      armed_q <= `SCPM_RST_VALID;
    end else if (security_start) begin
      armed_q <= valid_q;
    end
  end

  // Read value of the selected register, with unused bits at zero.
  always_comb begin
    rd_value = 32'h0000_0000;
    case (sel_reg)
      SCPM_REG_PAGE: begin
        rd_value = {28'h0000000, page_q};
      end
      SCPM_REG_ENTRY_SEL: begin
        rd_value = {27'h0000000, entry_q};
      end
      SCPM_REG_DATA: begin
        rd_value = {24'h000000, store_rdata};
      end
      SCPM_REG_MASK_LOW: begin
        rd_value = {24'h000000, mask_q[entry_q][7:0]};
      end
      SCPM_REG_MASK_HIGH: begin
        rd_value = {24'h000000, mask_high_view(mask_q[entry_q], ptr_q)};
      end
      SCPM_REG_VALID: begin
        rd_value = valid_q;
      end
      SCPM_REG_SECURITY: begin
        rd_value = {31'h00000000, run_q};
      end
      default: begin
        rd_value = 32'h0000_0000;
      end
    endcase
    if (bad_access) begin
      rd_value = 32'h0000_0000;
    end
  end

  // Answer is captured in the first access cycle and shown with pready in the second.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prdata_q <= `SCPM_RST_DATA;
    end else if (access_first) begin
      prdata_q <= apb_req_in.pwrite ? `SCPM_RST_DATA : rd_value;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      slverr_q <= 1'b0;
    end else if (access_first) begin
      slverr_q <= bad_access;
    end
  end

  always_comb begin
    apb_rsp_out.pready = wait_q;
    apb_rsp_out.pslverr = wait_q && slverr_q;
    apb_rsp_out.prdata = prdata_q;
  end

  always_comb begin
    for (int i = 0; i < `SCPM_ENTRIES; i++) begin
      entry_port_map_out[i*`SCPM_PORTS +: `SCPM_PORTS] = mask_q[i];
    end
  end

  assign entry_compare_en_out = run_q ? armed_q : `SCPM_RST_VALID;
  assign security_run_out = run_q;

endmodule

/* File: verilog/scpm_consts.svh */
// Purpose: Offsets, field positions, reset values and counts of the shared entry register block.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Included by the package and by the design modules.
`ifndef SCPM_CONSTS_SVH
`define SCPM_CONSTS_SVH

// Byte offsets on the APB.
`define SCPM_OFF_PAGE 8'h00
`define SCPM_OFF_ENTRY_SEL 8'h04
`define SCPM_OFF_SHARED_ENTRY_DATA 8'h08
`define SCPM_OFF_MASK_LOW 8'h0c
`define SCPM_OFF_MASK_HIGH 8'h10
`define SCPM_OFF_VALID 8'h14
`define SCPM_OFF_SECURITY 8'h18

// Register pages on which the entry data and masks decode.
`define SCPM_PAGE_FIRST 4'h9
`define SCPM_PAGE_LAST 4'hf

// Sizes.
`define SCPM_ENTRIES 32
`define SCPM_ENTRY_W 5
`define SCPM_PORTS 13
`define SCPM_ADDR_BYTES 6
`define SCPM_STORE_DEPTH 192
`define SCPM_STORE_AW 8
`define SCPM_PTR_LAST 3'h5

// Field positions in the mask high byte.
`define SCPM_MHI_PORT_W 5
`define SCPM_MHI_PTR_LSB 5

// Field positions in the security register.
`define SCPM_SEC_RUN_BIT 0

// Reset values.
`define SCPM_RST_PAGE 4'h0
`define SCPM_RST_ENTRY 5'h00
`define SCPM_RST_PTR 3'h0
`define SCPM_RST_MASK 13'h0000
`define SCPM_RST_VALID 32'h0000_0000
`define SCPM_RST_DATA 32'h0000_0000

`endif

/* File: verilog/scpm_pkg.sv */
// Purpose: Types shared by the shared entry register block.
// Assumes: Constants come from scpm_consts.svh.
// Notes: The APB request and answer travel as packed structs.
`include "scpm_consts.svh"

package scpm_pkg;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } scpm_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } scpm_apb_rsp_t;

  typedef enum logic [2:0] {
    SCPM_REG_PAGE,
    SCPM_REG_ENTRY_SEL,
    SCPM_REG_DATA,
    SCPM_REG_MASK_LOW,
    SCPM_REG_MASK_HIGH,
    SCPM_REG_VALID,
    SCPM_REG_SECURITY,
    SCPM_REG_NONE
  } scpm_reg_t;

endpackage

/* File: verilog/scpm_entry_store.sv */
// Purpose: Byte-wide store of the 48-bit shared station addresses.
// Assumes: One write or one read per clock; read data appear one edge after the request.
// Notes: Contents are not reset; the read data register is.
`timescale 1ns/10ps
`include "scpm_consts.svh"

module scpm_entry_store
  import scpm_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [`SCPM_STORE_AW-1:0] addr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out
);

  logic [7:0] mem_q [`SCPM_STORE_DEPTH];
  logic [7:0] rdata_q;

  always_ff @(posedge mclk_in) begin
    if (wr_en_in) begin
      mem_q[addr_in] <= wdata_in;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_q <= 8'h00;
    end else if (rd_en_in) begin
      rdata_q <= mem_q[addr_in];
    end
  end

  assign rdata_out = rdata_q;

endmodule

/* File: verif/scpm_regs_sva.sv */
// Purpose: Port checks on the shared entry register bank.
// Assumes: Sees only the top module ports.
// Notes: Bound below the module.
`timescale 1ns/10ps
`include "scpm_consts.svh"
module scpm_regs_sva
  import scpm_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire scpm_apb_req_t apb_req_in,
  input wire scpm_apb_rsp_t apb_rsp_out,
  input wire logic [`SCPM_ENTRIES*`SCPM_PORTS-1:0] entry_port_map_out,
  input wire logic [`SCPM_ENTRIES-1:0] entry_compare_en_out,
  input wire logic security_run_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  wire logic rdy = apb_rsp_out.pready;
  wire logic wr = apb_req_in.pwrite;
  wire logic [7:0] ad = apb_req_in.paddr;
  sequence s_setup;
    apb_req_in.psel && !apb_req_in.penable;
  endsequence
  sequence s_wait;
    !rdy ##1 rdy;
  endsequence
  a_ready_wait: assert property (s_setup |=> s_wait)
    else $error("pready not in second access cycle");
  a_ready_pulse: assert property (rdy |=> !rdy)
    else $error("pready longer than one cycle");
  a_err_ready: assert property (apb_rsp_out.pslverr |-> rdy)
    else $error("pslverr without pready");
  a_write_rdata: assert property (rdy && wr |-> apb_rsp_out.prdata == 32'h0)
    else $error("read data not zero on write");
  a_byte_wide: assert property (rdy && !wr && ad inside {8'h08, 8'h0c, 8'h10} |->
    apb_rsp_out.prdata[31:8] == 24'h0)
    else $error("byte register wider than eight bits");
  a_map_hold: assert property (!(rdy && wr) |=> $stable(entry_port_map_out))
    else $error("port map moved without a write");
  a_err_nowrite: assert property (rdy && wr && apb_rsp_out.pslverr |=> $stable(entry_port_map_out))
    else $error("refused write changed port map");
  a_cmp_off: assert property (!security_run_out |-> entry_compare_en_out == 32'h0)
    else $error("compare enabled while stopped");
  a_cmp_frozen: assert property (security_run_out |=> !security_run_out || $stable(entry_compare_en_out))
    else $error("compare set moved while running");
endmodule
bind scpm_regs scpm_regs_sva u_scpm_regs_sva (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .apb_req_in(apb_req_in),
  .apb_rsp_out(apb_rsp_out), .entry_port_map_out(entry_port_map_out),
  .entry_compare_en_out(entry_compare_en_out), .security_run_out(security_run_out));

/* File: verif/testbench.sv */
// Purpose: Self-checking bench of the shared entry register bank.
// Assumes: APB answers after one wait state.
// Notes: Random data from an xorshift seeded with 71.
`timescale 1ns/10ps
`include "scpm_consts.svh"
`define CHK(n, e, s) begin \
  total_checks++; \
  if ((s) !== (e)) begin \
    fails++; \
    $display("Error %s exp %h got %h", n, e, s); \
  end \
end
module testbench
  import scpm_pkg::*;
;
  logic mclk_in = 1'h0;
  logic rst_n_in = 1'h0;
  scpm_apb_req_t req = '0;
  scpm_apb_rsp_t rsp;
  logic [`SCPM_ENTRIES*`SCPM_PORTS-1:0] map;
  logic [`SCPM_ENTRIES-1:0] cmp;
  logic run;
  int fails = 0;
  int total_checks = 0;
  int e;
  logic [31:0] seed = 32'h47;
  logic [31:0] rd;
  logic [31:0] v;
  logic err;
  logic [12:0] exp_map [`SCPM_ENTRIES] = '{default: 13'h0};
  logic [7:0] ab [6];
  always #5 mclk_in = ~mclk_in;
  scpm_regs u_scpm_regs (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .apb_req_in(req), .apb_rsp_out(rsp),
    .entry_port_map_out(map), .entry_compare_en_out(cmp), .security_run_out(run));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] hi_exp(input logic [12:0] m, input logic [2:0] p);
    return {24'h0, p, m[12:8]};
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_in);
    req <= '{1'h1, 1'h0, w, a, d};
    @(posedge mclk_in);
    req.penable <= 1'h1;
    do begin
      @(posedge mclk_in);
      n++;
    end while (rsp.pready !== 1'h1 && n < 20);
    if (n >= 20) fails++;
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'h0;
    req.penable <= 1'h0;
  endtask
  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    fails++;
    print_verdict();
  end
  initial begin
    repeat (2) @(posedge mclk_in);
    rst_n_in <= 1'h1;
    `CHK("reset map", '0, map)
    for (int p = 'h0; p < 'h10; p++) begin
      apb(1'h1, `SCPM_OFF_PAGE, p);
      apb(1'h0, `SCPM_OFF_MASK_HIGH, 32'h0);
      `CHK("page err", p < 'h9, err)
      if (p == 'h9) `CHK("reset high", 32'h0, rd)
    end
    for (int i = 0; i < 10; i++) begin
      e = i < 2 ? i * 31 : rnd() & 32'h1f;
      v = rnd();
      apb(1'h1, `SCPM_OFF_ENTRY_SEL, e);
      apb(1'h1, `SCPM_OFF_MASK_LOW, v & 32'hff);
      apb(1'h1, `SCPM_OFF_MASK_HIGH, (v >> 8) & 32'hff);
      exp_map[e] = v[12:0];
      apb(1'h0, `SCPM_OFF_MASK_HIGH, 32'h0);
      `CHK("mask high", hi_exp(v[12:0], 3'h0), rd)
      apb(1'h0, `SCPM_OFF_MASK_LOW, 32'h0);
      `CHK("mask low", v & 32'hff, rd)
    end
    for (int i = 0; i < 32; i++) `CHK("port map", exp_map[i], map[i*13 +: 13])
    for (int k = 0; k < 12; k++) begin
      if (k < 6) ab[k] = 8'(rnd());
      apb(k < 6, `SCPM_OFF_SHARED_ENTRY_DATA, {24'h0, ab[k % 6]});
      if (k >= 6) `CHK("entry byte", {24'h0, ab[k - 6]}, rd)
      apb(1'h0, `SCPM_OFF_MASK_HIGH, 32'h0);
      `CHK("byte pointer", hi_exp(exp_map[e], 3'((k + 1) % 6)), rd)
    end
    repeat (3) apb(1'h1, `SCPM_OFF_SHARED_ENTRY_DATA, 32'hee);
    apb(1'h1, `SCPM_OFF_ENTRY_SEL, e);
    apb(1'h0, `SCPM_OFF_MASK_HIGH, 32'h0);
    `CHK("select pointer", hi_exp(exp_map[e], 3'h0), rd)
    apb(1'h1, `SCPM_OFF_PAGE, 32'h8);
    apb(1'h1, `SCPM_OFF_MASK_LOW, ~exp_map[e] & 32'hff);
    `CHK("refused mask err", 1'h1, err)
    apb(1'h1, `SCPM_OFF_SHARED_ENTRY_DATA, 32'h55);
    `CHK("refused data err", 1'h1, err)
    apb(1'h1, `SCPM_OFF_PAGE, 32'h9);
    apb(1'h0, `SCPM_OFF_MASK_HIGH, 32'h0);
    `CHK("refused pointer", hi_exp(exp_map[e], 3'h0), rd)
    apb(1'h0, `SCPM_OFF_MASK_LOW, 32'h0);
    `CHK("refused mask", {24'h0, exp_map[e][7:0]}, rd)
    v = rnd();
    apb(1'h0, `SCPM_OFF_VALID, 32'h0);
    apb(1'h1, `SCPM_OFF_VALID, rd | v);
    apb(1'h1, `SCPM_OFF_SECURITY, 32'h1);
    apb(1'h0, `SCPM_OFF_VALID, 32'h0);
    `CHK("run on", 1'h1, run)
    apb(1'h1, `SCPM_OFF_VALID, rd ^ 32'hffff_ffff);
    apb(1'h0, `SCPM_OFF_VALID, 32'h0);
    `CHK("valid read", ~v, rd)
    `CHK("compare set", v, cmp)
    apb(1'h1, `SCPM_OFF_SECURITY, 32'h0);
    apb(1'h0, 8'h1c, 32'h0);
    `CHK("unmapped err", 1'h1, err)
    `CHK("compare off", 32'h0, cmp)
    `CHK("run off", 1'h0, run)
    apb(1'h0, 8'h09, 32'h0);
    `CHK("misaligned", 1'h1, err)
    print_verdict();
  end
endmodule
